// ### include/eeac_pkg.sv
// Constants and types of the external EEPROM access unit
package eeac_pkg;
  localparam logic [7:0] ADR_LO_OFS = 8'h09;
  localparam logic [7:0] ADR_HI_OFS = 8'h0A;
  localparam logic [7:0] DATA_OFS   = 8'h0B;
  localparam logic [7:0] CTL_OFS    = 8'h0C;
  localparam logic [7:0] ADR_LO_RST = 8'h00;
  localparam logic [7:0] ADR_HI_RST = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam int ERR_BIT   = 5;
  localparam int BUSY_BIT  = 4;
  localparam int ABORT_BIT = 3;
  localparam int START_BIT = 2;
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOAD  = 2'h2,
    OP_STORE = 2'h3
  } eeac_op_e;
  // Serial memory device type code, chip selects come from address
  localparam logic [3:0] EE_CTRL_CODE = 4'hA;
  // Configuration bytes moved by load and store, from memory byte 0
  localparam logic [3:0] CFG_LAST = 4'hF;
  localparam int LINK_PERIOD_PS = 32000;
  localparam int SCL_QTR_NS     = 2500;
  localparam int QTR_CYC =
    (SCL_QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int EE_WR_NS = 5000000;
  localparam longint WR_WAIT_CYC =
    (longint'(EE_WR_NS) * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  typedef enum logic [1:0] {SY_IDLE, SY_ISSUE, SY_JOB} eeac_sys_e;
  typedef enum logic [2:0] {
    LK_IDLE, LK_START, LK_BIT, LK_RSTART, LK_STOP, LK_WAIT
  } eeac_lk_e;
endpackage

// ### verilog/eeac_top.sv
// External EEPROM access unit: registers, sequencer and serial master
// How it works
// - address is low reg [2:0] plus high reg
// - data reg holds read or write byte
// - driven versus sampled data mismatch sets error
// - missing memory acknowledge sets error flag
// - error flag sticks until written one
// - busy bit shows access in progress
// - abort stops access, clears busy at once
// - aborted write leaves memory contents undefined
// - abort and start read back zero
// - start one launches selected operation
// - start needs idle unit and running clock
// - code 00 reads one byte
// - code 01 writes one byte
// - code 10 loads memory into config registers
// - code 11 stores config registers to memory
// - operation field reads back zero
// - clock running status gates every start
// - boot load at reset, flag until done
`timescale 1ns/10ps
module eeac_top
  import eeac_pkg::*;
#(
  parameter int WR_WAIT = int'(WR_WAIT_CYC),
  parameter int QTR     = QTR_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       clk_link,
  input  wire logic       system_clock_running,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            eeprom_busy_flag,
  output logic            boot_in_progress,
  output logic      [3:0] cfg_index,
  output logic      [7:0] cfg_wdata,
  output logic            cfg_we,
  input  wire logic [7:0] cfg_rdata,
  output logic            eeprom_serial_clock_line,
  input  wire logic       eeprom_serial_data_line_i,
  output logic            eeprom_serial_data_line_o,
  output logic            eeprom_serial_data_line_oe
);
  // System side state
  eeac_sys_e   st_q;
  eeac_op_e    op_q;
  logic [7:0]  adr_lo_q;
  logic [7:0]  adr_hi_q;
  logic [7:0]  data_q;
  logic        err_q;
  logic        busy_q;
  logic        boot_q;
  logic        bulk_q;
  logic [3:0]  idx_q;
  logic        start_tg_q;
  logic        abort_tg_q;
  logic        job_rd_q;
  logic [10:0] job_addr_q;
  logic [7:0]  job_data_q;
  logic [7:0]  cfg_wdata_q;
  logic [7:0]  rdata_q;
  logic        dn1;
  logic        dn2;
  logic        dn3;
  logic        done_ev;
  logic        wr_ctl;
  logic        start_req;
  logic        abort_req;
  logic        job_end;
  // Link side state
  eeac_lk_e    st_l;
  logic [1:0]  ph_l;
  logic [6:0]  qc_l;
  logic [3:0]  bit_l;
  logic [2:0]  seg_l;
  logic [7:0]  sh_l;
  logic        rd_l;
  logic [10:0] addr_l;
  logic [7:0]  wd_l;
  logic        err_l;
  logic [7:0]  rdat_l;
  logic        done_tg_l;
  logic        st_ack_l;
  logic        ab_ack_l;
  logic        quiet_l;
  logic [17:0] wt_l;
  logic        scl_q;
  logic        pull_q;
  logic        lrst1;
  logic        lrst_n;
  logic        ce1;
  logic        ce_l;
  logic        st1;
  logic        st_s;
  logic        ab1;
  logic        ab_s;
  logic        sda1;
  logic        sda_s;
  logic        tick;
  logic        rcv;
  logic        m_drv;
  logic        m_val;

  assign reg_rdata        = rdata_q;
  assign eeprom_busy_flag = busy_q;
  assign boot_in_progress = boot_q;
  assign cfg_index        = idx_q;
  assign cfg_wdata        = cfg_wdata_q;
  // Strobe rides the done cycle, so cfg_index still names this byte
  assign cfg_we           = job_end && op_q == OP_LOAD && !err_l;
  assign eeprom_serial_clock_line   = scl_q;
  // Open drain: only ever pulls low
  assign eeprom_serial_data_line_o  = 1'b0;
  assign eeprom_serial_data_line_oe = pull_q;

  assign wr_ctl    = ce && reg_wr && (reg_addr == CTL_OFS);
  assign start_req = wr_ctl && reg_wdata[START_BIT] && !busy_q
                     && system_clock_running;
  assign abort_req = wr_ctl && reg_wdata[ABORT_BIT] && busy_q;
  assign done_ev   = dn2 ^ dn3;
  assign job_end   = ce && done_ev && (st_q == SY_JOB) && !abort_req;

  // Done toggle from the link; result words are held stable there
  always_ff @(posedge clk_sys) begin
    dn1 <= done_tg_l;
    if (!resetn) begin
      dn2 <= 1'b0;
      dn3 <= 1'b0;
    end else if (ce) begin
      dn2 <= dn1;
      dn3 <= dn2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      adr_lo_q <= ADR_LO_RST;
      adr_hi_q <= ADR_HI_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == ADR_LO_OFS) adr_lo_q <= reg_wdata;
      if (reg_addr == ADR_HI_OFS) adr_hi_q <= reg_wdata;
    end
  end

  // Hardware load wins over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      data_q <= DATA_RST;
    end else if (ce) begin
      if (job_end && op_q == OP_READ && !err_l) begin
        data_q <= rdat_l;
      end else if (reg_wr && reg_addr == DATA_OFS) begin
        data_q <= reg_wdata;
      end
    end
  end

  // A failing job in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      err_q <= 1'b0;
    end else if (ce) begin
      err_q <= (job_end && err_l)
               || (err_q && !(wr_ctl && reg_wdata[ERR_BIT]));
    end
  end

  // The link holds its byte well before the done toggle arrives
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_wdata_q <= 8'h00;
    end else if (ce) begin
      cfg_wdata_q <= rdat_l;
    end
  end

  // Operation sequencer; bulk ops are chains of single byte jobs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q       <= SY_IDLE;
      op_q       <= OP_READ;
      busy_q     <= 1'b0;
      boot_q     <= 1'b1;
      bulk_q     <= 1'b0;
      idx_q      <= 4'h0;
      start_tg_q <= 1'b0;
      abort_tg_q <= 1'b0;
      job_rd_q   <= 1'b0;
      job_addr_q <= 11'h000;
      job_data_q <= 8'h00;
    end else if (ce) begin
      if (abort_req) begin
        // Stopping a write mid cycle may corrupt the memory byte
        abort_tg_q <= ~abort_tg_q;
        busy_q     <= 1'b0;
        boot_q     <= 1'b0;
        st_q       <= SY_IDLE;
      end else begin
        unique case (st_q)
          SY_IDLE: begin
            if (start_req) begin
              op_q   <= eeac_op_e'(reg_wdata[1:0]);
              bulk_q <= reg_wdata[1];
              idx_q  <= 4'h0;
              busy_q <= 1'b1;
              st_q   <= SY_ISSUE;
            end else if (boot_q && system_clock_running) begin
              op_q   <= OP_LOAD;
              bulk_q <= 1'b1;
              idx_q  <= 4'h0;
              busy_q <= 1'b1;
              st_q   <= SY_ISSUE;
            end
          end
          SY_ISSUE: begin
            job_rd_q <= (op_q == OP_READ) || (op_q == OP_LOAD);
            if (bulk_q) begin
              job_addr_q <= {7'h00, idx_q};
            end else begin
              // Bits [7:3] of the low register are left out
              job_addr_q <= {adr_hi_q, adr_lo_q[2:0]};
            end
            job_data_q <= (op_q == OP_STORE) ? cfg_rdata
                                             : data_q;
            start_tg_q <= ~start_tg_q;
            st_q       <= SY_JOB;
          end
          SY_JOB: begin
            if (done_ev) begin
              if (err_l || !bulk_q || idx_q == CFG_LAST) begin
                busy_q <= 1'b0;
                boot_q <= 1'b0;
                st_q   <= SY_IDLE;
              end else begin
                idx_q <= idx_q + 4'h1;
                st_q  <= SY_ISSUE;
              end
            end
          end
          default: st_q <= SY_IDLE;
        endcase
      end
    end
  end

  // Registered read port; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      unique case (reg_addr)
        ADR_LO_OFS: rdata_q <= adr_lo_q;
        ADR_HI_OFS: rdata_q <= adr_hi_q;
        DATA_OFS:   rdata_q <= data_q;
        CTL_OFS:    rdata_q <= {2'h0, err_q, busy_q, 4'h0};
        default:    rdata_q <= 8'h00;
      endcase
    end
  end

  // Link domain synchronisers
  always_ff @(posedge clk_link) begin
    lrst1  <= resetn;
    lrst_n <= lrst1;
    ce1    <= ce;
    ce_l   <= ce1;
    st1    <= start_tg_q;
    st_s   <= st1;
    ab1    <= abort_tg_q;
    ab_s   <= ab1;
    sda1   <= eeprom_serial_data_line_i;
    sda_s  <= sda1;
  end

  assign tick  = (qc_l == 7'(QTR - 1));
  assign rcv   = (seg_l == 3'h4);
  assign m_drv = rcv ? (bit_l == 4'h8) : (bit_l != 4'h8);
  // Master acknowledge slot sends NACK to end the read
  assign m_val = (bit_l == 4'h8) ? 1'b1 : sh_l[7];

  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      st_l      <= LK_IDLE;
      ph_l      <= 2'h0;
      qc_l      <= 7'h00;
      bit_l     <= 4'h0;
      seg_l     <= 3'h0;
      sh_l      <= 8'h00;
      rd_l      <= 1'b0;
      addr_l    <= 11'h000;
      wd_l      <= 8'h00;
      err_l     <= 1'b0;
      rdat_l    <= 8'h00;
      done_tg_l <= 1'b0;
      st_ack_l  <= 1'b0;
      ab_ack_l  <= 1'b0;
      quiet_l   <= 1'b0;
      wt_l      <= 18'h00000;
    end else if (ce_l) begin
      qc_l <= tick ? 7'h00 : qc_l + 7'h01;
      if (ab_s != ab_ack_l) begin
        // Aborted jobs end without a done toggle
        ab_ack_l <= ab_s;
        // A start landing with the abort is dropped, not run later
        st_ack_l <= st_s;
        quiet_l  <= 1'b1;
        if (st_l == LK_WAIT) begin
          st_l <= LK_IDLE;
        end else if (st_l != LK_IDLE && st_l != LK_STOP) begin
          st_l <= LK_STOP;
          ph_l <= 2'h0;
        end
      end else if (st_l == LK_IDLE) begin
        if (st_s != st_ack_l) begin
          st_ack_l <= st_s;
          rd_l     <= job_rd_q;
          addr_l   <= job_addr_q;
          wd_l     <= job_data_q;
          err_l    <= 1'b0;
          quiet_l  <= 1'b0;
          ph_l     <= 2'h0;
          st_l     <= LK_START;
        end
      end else if (st_l == LK_WAIT) begin
        wt_l <= wt_l + 18'h00001;
        if (wt_l == 18'(WR_WAIT - 1)) begin
          done_tg_l <= ~done_tg_l;
          st_l      <= LK_IDLE;
        end
      end else if (tick) begin
        ph_l <= ph_l + 2'h1;
        unique case (st_l)
          LK_START: if (ph_l == 2'h3) begin
            seg_l <= 3'h0;
            bit_l <= 4'h0;
            sh_l  <= {EE_CTRL_CODE, addr_l[10:8], 1'b0};
            st_l  <= LK_BIT;
          end
          LK_RSTART: if (ph_l == 2'h3) begin
            seg_l <= 3'h3;
            bit_l <= 4'h0;
            sh_l  <= {EE_CTRL_CODE, addr_l[10:8], 1'b1};
            st_l  <= LK_BIT;
          end
          LK_BIT: begin
            if (ph_l == 2'h2) begin
              if (m_drv && sda_s != m_val) err_l <= 1'b1;
              if (bit_l == 4'h8 && !rcv && sda_s) begin
                err_l <= 1'b1;
              end
              if (rcv && bit_l != 4'h8) sh_l <= {sh_l[6:0], sda_s};
            end
            if (ph_l == 2'h3) begin
              if (err_l) begin
                st_l <= LK_STOP;
              end else if (bit_l != 4'h8) begin
                bit_l <= bit_l + 4'h1;
                if (!rcv) sh_l <= {sh_l[6:0], 1'b0};
              end else begin
                bit_l <= 4'h0;
                unique case (seg_l)
                  3'h0: begin
                    seg_l <= 3'h1;
                    sh_l  <= addr_l[7:0];
                  end
                  3'h1: begin
                    if (rd_l) begin
                      st_l <= LK_RSTART;
                    end else begin
                      seg_l <= 3'h2;
                      sh_l  <= wd_l;
                    end
                  end
                  3'h3: seg_l <= 3'h4;
                  3'h4: begin
                    rdat_l <= sh_l;
                    st_l   <= LK_STOP;
                  end
                  default: st_l <= LK_STOP;
                endcase
              end
            end
          end
          LK_STOP: if (ph_l == 2'h3) begin
            if (quiet_l) begin
              st_l <= LK_IDLE;
            end else if (!rd_l && !err_l) begin
              // Memory needs its internal write time before next job
              wt_l <= 18'h00000;
              st_l <= LK_WAIT;
            end else begin
              done_tg_l <= ~done_tg_l;
              st_l      <= LK_IDLE;
            end
          end
          default: st_l <= LK_IDLE;
        endcase
      end
    end
  end

  // Pin levels follow the quarter phase of the current step
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      scl_q  <= 1'b1;
      pull_q <= 1'b0;
    end else if (ce_l) begin
      unique case (st_l)
        LK_START: begin
          scl_q  <= ph_l < 2'h2;
          pull_q <= ph_l != 2'h0;
        end
        LK_BIT: begin
          scl_q  <= ph_l == 2'h1 || ph_l == 2'h2;
          pull_q <= m_drv && !m_val;
        end
        LK_RSTART: begin
          scl_q  <= ph_l == 2'h1 || ph_l == 2'h2;
          pull_q <= ph_l >= 2'h2;
        end
        LK_STOP: begin
          scl_q  <= ph_l != 2'h0;
          pull_q <= ph_l < 2'h2;
        end
        default: begin
          scl_q  <= 1'b1;
          pull_q <= 1'b0;
        end
      endcase
    end
  end

  abort_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    abort_req |=> !busy_q && st_q == SY_IDLE)
    else $error("abort did not clear busy");
  start_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    start_req |=> busy_q ##1 st_q == SY_JOB)
    else $error("accepted start did not set busy");
  no_start_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!busy_q && !boot_q && (!system_clock_running ||
     (wr_ctl && !reg_wdata[START_BIT]))) |=> !busy_q)
    else $error("access began without a valid start");
  ctl_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ce && reg_rd && reg_addr == CTL_OFS) |=> rdata_q[3:0] == 4'h0)
    else $error("control low bits read nonzero");
  err_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (err_q && !(wr_ctl && reg_wdata[ERR_BIT])) |=> err_q)
    else $error("error flag dropped without clear");
  err_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_ctl && reg_wdata[ERR_BIT] && !(job_end && err_l)) |=> !err_q)
    else $error("error flag not cleared by write one");
  read_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (job_end && op_q == OP_READ && !err_l) |=> data_q == $past(rdat_l))
    else $error("read byte not placed in data register");
  addr_form_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ce && st_q == SY_ISSUE && !bulk_q && !abort_req && !reg_wr)
    |=> job_addr_q == {adr_hi_q, adr_lo_q[2:0]})
    else $error("byte address formed wrongly");
  boot_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(boot_q) |-> !busy_q)
    else $error("boot flag fell while still busy");
  nack_err_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (ce_l && tick && st_l == LK_BIT && ph_l == 2'h2 && bit_l == 4'h8
     && !rcv && sda_s && ab_s == ab_ack_l) |=> err_l)
    else $error("missing acknowledge not flagged");
  drive_err_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (ce_l && tick && st_l == LK_BIT && ph_l == 2'h2 && m_drv
     && sda_s != m_val && ab_s == ab_ack_l) |=> err_l)
    else $error("line mismatch not flagged");

  read_done_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    job_end && op_q == OP_READ && !err_l);
  write_done_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    job_end && op_q == OP_WRITE);
  bulk_done_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    job_end && bulk_q && idx_q == CFG_LAST);
  abort_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    abort_req);
endmodule // eeac_top

// ### bench/eeac_mem_model.sv
// Behavioural serial EEPROM on the far side of the access unit's link
`timescale 1ns/10ps
module eeac_mem_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack,
  input  wire logic jam,
  output logic      pull_low
);
  logic [7:0]  mem [0:2047];
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [3:0]  bit_n;
  logic [1:0]  byte_n;
  logic [10:0] adr;
  logic        act;
  logic        rd;
  logic        drv;

  // Jam holds the line low to provoke a driven-versus-sampled fault
  assign pull_low = jam | drv;

  initial begin
    for (int k = 0; k < 2048; k++) begin
      mem[k] = k[7:0] ^ {k[10:8], 5'h15};
    end
    act = 1'b0;
    drv = 1'b0;
    rd = 1'b0;
    adr = 11'h000;
    bit_n = 4'h0;
    byte_n = 2'h0;
  end

  always @(negedge sda) if (scl) begin
    act = 1'b1;
    // The clock fall after a start wraps this to the first bit
    bit_n = 4'hF;
    byte_n = 2'h0;
    rd = 1'b0;
    drv = 1'b0;
  end

  always @(posedge sda) if (scl) begin
    act = 1'b0;
    drv = 1'b0;
  end

  // A master not-acknowledge ends the read, so the line is left free
  always @(posedge scl) if (act) begin
    if (bit_n < 4'h8) begin
      sh = {sh[6:0], sda};
    end else if (rd && sda) begin
      act = 1'b0;
    end
  end

  always @(negedge scl) if (act) begin
    if (bit_n == 4'h8) begin
      bit_n = 4'h0;
      drv = rd & ~tx[7];
    end else begin
      bit_n = bit_n + 4'h1;
      if (rd) begin
        drv = (bit_n < 4'h8) & ~tx[3'(7 - bit_n)];
      end else if (bit_n == 4'h8) begin
        if (byte_n == 2'h0) begin
          rd = sh[0];
          adr[10:8] = sh[3:1];
          tx = mem[adr];
        end else if (byte_n == 2'h1) begin
          adr[7:0] = sh;
        end else begin
          mem[adr] = sh;
        end
        if (byte_n != 2'h2) begin
          byte_n = byte_n + 2'h1;
        end
        drv = ~nack;
      end
    end
  end
endmodule // eeac_mem_model

// ### bench/ext_eeprom_access_ctrl_bench.sv
// Self-checking bench for the external EEPROM access unit
`timescale 1ns/10ps
module ext_eeprom_access_ctrl_bench;
  import eeac_pkg::*;
  logic        clk_sys     = 1'b0;
  logic        clk_link    = 1'b0;
  logic        resetn      = 1'b0;
  logic        scr         = 1'b1;
  logic [7:0]  reg_addr    = 8'h00;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        nack        = 1'b0;
  logic        jam         = 1'b0;
  logic [7:0]  reg_rdata;
  logic        busy;
  logic        boot;
  logic [3:0]  cfg_index;
  logic [7:0]  cfg_wdata;
  logic        cfg_we;
  logic [7:0]  cfg_rdata;
  logic        scl;
  logic        sda_oe;
  logic        pull_low;
  wire         sda;
  int          errors      = 0;
  int          checks_done = 0;
  int          we_n        = 0;
  int          seed        = 32'hE6A4;
  logic [7:0]  d;
  logic [10:0] a;

  function automatic logic [7:0] mem_init(logic [10:0] k);
    return k[7:0] ^ {k[10:8], 5'h15};
  endfunction

  function automatic logic [7:0] cfg_val(logic [3:0] i);
    return {i, ~i} ^ 8'h3C;
  endfunction

  always #10 clk_sys = ~clk_sys;
  // Offset start keeps the link clock out of step with the system clock
  initial begin
    #7;
    forever #16 clk_link = ~clk_link;
  end

  assign sda = ~(sda_oe | pull_low);
  assign cfg_rdata = cfg_val(cfg_index);

  // Short quarter step keeps bulk loads and stores within the run budget
  eeac_top #(.WR_WAIT(20), .QTR(4)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .clk_link(clk_link),
    .system_clock_running(scr), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .eeprom_busy_flag(busy), .boot_in_progress(boot),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we),
    .cfg_rdata(cfg_rdata), .eeprom_serial_clock_line(scl),
    .eeprom_serial_data_line_i(sda), .eeprom_serial_data_line_o(),
    .eeprom_serial_data_line_oe(sda_oe)
  );

  eeac_mem_model mem_u (
    .scl(scl), .sda(sda), .nack(nack), .jam(jam), .pull_low(pull_low)
  );

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] ad, logic [7:0] dat);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rc(string what, logic [7:0] ad, logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (busy !== 1'b0 && n < 30000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("busy_end", busy, 8'h00);
  endtask

  // Address low byte carries junk in [7:5] but keeps [4:3] clear
  task automatic ee_op(logic [10:0] ad, logic [1:0] op);
    wr(ADR_LO_OFS, {3'b101, 2'b00, ad[2:0]});
    wr(ADR_HI_OFS, ad[10:3]);
    wr(CTL_OFS, {6'h01, op});
  endtask

  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) if (cfg_we === 1'b1) begin
    we_n++;
    chk("cfg_wdata", cfg_wdata, mem_init(11'(cfg_index)));
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("busy", busy, 8'h01);
    chk("boot", boot, 8'h01);
    rc("adr_lo", ADR_LO_OFS, ADR_LO_RST);
    rc("adr_hi", ADR_HI_OFS, ADR_HI_RST);
    rc("data", DATA_OFS, DATA_RST);
    rc("unmapped", 8'h0D, 8'h00);
    wait_idle();
    chk("boot", boot, 8'h00);
    chk("loads", 8'(we_n), 8'h10);
    wr(CTL_OFS, 8'h0B);
    rc("ctl", CTL_OFS, 8'h00);
    @(posedge clk_sys);
    scr <= 1'b0;
    ee_op(11'h000, OP_READ);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("busy", busy, 8'h00);
    @(posedge clk_sys);
    scr <= 1'b1;
    ee_op(11'h5A3, OP_READ);
    wait_idle();
    rc("data", DATA_OFS, mem_init(11'h5A3));
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 11'h7FF : 11'(16 + ($unsigned($random(seed)) % 2032));
      d = 8'($random(seed));
      wr(DATA_OFS, d);
      ee_op(a, OP_WRITE);
      rc("ctl", CTL_OFS, 8'h10);
      wr(CTL_OFS, 8'h04);
      wait_idle();
      wr(DATA_OFS, ~d);
      ee_op(a, OP_READ);
      wait_idle();
      rc("adr_lo", ADR_LO_OFS, {5'b10100, a[2:0]});
      rc("data", DATA_OFS, d);
    end
    // First pass jams the data line, second refuses to acknowledge
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_sys);
      {jam, nack} <= (f == 0) ? 2'b10 : 2'b01;
      ee_op(11'h020, OP_READ);
      wait_idle();
      @(posedge clk_sys);
      {jam, nack} <= 2'b00;
      rc("ctl", CTL_OFS, 8'h20);
      rc("ctl", CTL_OFS, 8'h20);
      wr(CTL_OFS, 8'h20);
      rc("ctl", CTL_OFS, 8'h00);
    end
    we_n = 0;
    wr(CTL_OFS, {6'h01, OP_LOAD});
    for (int n = 0; n < 5000 && we_n < 2; n++) @(posedge clk_sys);
    wr(CTL_OFS, 8'h08);
    @(posedge clk_sys);
    #1;
    chk("busy", busy, 8'h00);
    repeat (4000) @(posedge clk_sys);
    chk("loads", 8'(we_n), 8'h02);
    ee_op(11'h000, OP_STORE);
    wait_idle();
    for (int k = 0; k < 16; k += 15) begin
      ee_op(11'(k), OP_READ);
      wait_idle();
      rc("stored", DATA_OFS, cfg_val(4'(k)));
    end
    test_done();
  end
endmodule // ext_eeprom_access_ctrl_bench
